// [core/lbw_core.sv]
// Serial port extensions: auto-baud end, wake on break, break send and receive
// Assumes a plain register port on clk_i and an asynchronous receive pin
`include "lbw_defs.svh"

// Notes on behaviour
// RULE1 - Reading receive data clears pending after auto-baud
// RULE2 - Software write clears auto-baud overflow flag
// RULE3 - Overflow stays set while auto-baud enabled
// RULE4 - Asleep: no character reception
// RULE5 - Wake detection only in asynchronous mode
// RULE6 - Wake enabled: receiver held idle
// RULE7 - Wake event is one falling receive edge
// RULE8 - Wake event sets receive pending flag
// RULE9 - Receive data read clears wake pending
// RULE10 - Rising edge ending break clears wake enable
// RULE11 - Non-zero character wakes at first rise
// RULE12 - Remote sends zero wake character, ten bits
// RULE13 - Software checks receiver idle before wake
// RULE14 - Break is start, twelve zeros, stop
// RULE15 - Data write with break-send starts break
// RULE16 - Break-send self clears after break stop bit
// RULE17 - Shift-empty status tracks break like characters
// RULE18 - Sync byte queued follows break directly
// RULE19 - Transmit buffer empty flag raised when empty
// RULE20 - Received break: pending, framing error, zero
// RULE21 - Wake detect, then next byte, two interrupts
// RULE22 - Auto-baud may be armed before sleep
// RULE23 - Sixteen-bit overflow; fifth rise ends measurement
// RULE24 - Auto-baud holds receiver idle until done
// RULE25 - Receive line synchronised before edge detection
module lbw_core
    import lbw_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    input  wire logic        rxd_i,
    input  wire logic        sleep_i,
    output logic             txd_o,
    output logic             rx_pending_o,
    output logic             tx_buffer_empty_o,
    output logic             tx_shift_empty_o
);
    // ==========================================================
    // Receive line and edges
    logic rx_s;
    logic rx_prev_reg;
    logic rx_fall;
    logic rx_rise;

    // Pin passes two flops before edge logic [RULE25]
    lbw_sync u_rx_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (rxd_i),
        .q_o     (rx_s)
    );

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rx_prev_reg <= 1'b1;
        else rx_prev_reg <= rx_s;
    end

    assign rx_fall = rx_prev_reg & ~rx_s;
    assign rx_rise = ~rx_prev_reg & rx_s;

    // ==========================================================
    // Register decode and control bits
    logic        wr_baud, wr_txctl, wr_txdata, wr_div, rd_rxdata;
    logic        autobaud_enable_reg, autobaud_overflow_flag_reg;
    logic        wake_enable_reg, wake_seen_reg, transmit_enable_reg;
    logic        break_send_bit_reg, sync_mode_reg;
    logic [15:0] divisor_reg;
    logic [15:0] ab_cnt_reg;
    logic        rx_pending_flag_reg, framing_error_flag_reg;
    logic [7:0]  rx_data_reg;
    logic        wake_event, ab_done, ab_ovf_set, rx_done, tx_brk_done;

    assign wr_baud   = wr_i && (addr_i == `LBW_A_BAUD);
    assign wr_txctl  = wr_i && (addr_i == `LBW_A_TXCTL);
    assign wr_txdata = wr_i && (addr_i == `LBW_A_TXDATA);
    assign wr_div    = wr_i && (addr_i == `LBW_A_DIV);
    assign rd_rxdata = rd_i && (addr_i == `LBW_A_RXDATA);

    // Wake is refused in synchronous mode [RULE5]
    assign wake_event = wake_enable_reg && !sync_mode_reg && !wake_seen_reg && rx_fall; // [RULE7]

    // Wake enable: software write wins, ending rise clears it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_enable_reg <= 1'b0;
            wake_seen_reg   <= 1'b0;
        end else begin
            if (wr_baud) wake_enable_reg <= wdata_i[`LBW_B_WAKE] & ~sync_mode_reg; // [RULE5]
            else if (wake_seen_reg && rx_rise) wake_enable_reg <= 1'b0; // [RULE10] [RULE11]
            if (!wake_enable_reg || (wake_seen_reg && rx_rise)) wake_seen_reg <= 1'b0;
            else if (wake_event) wake_seen_reg <= 1'b1;
        end
    end

    // Auto-baud enable, overflow flag and divisor
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            autobaud_enable_reg        <= 1'b0;
            autobaud_overflow_flag_reg <= 1'b0;
            divisor_reg                <= `LBW_DIV_RST;
        end else begin
            if (wr_baud) autobaud_enable_reg <= wdata_i[`LBW_B_AUTOBAUD_ENABLE];
            else if (ab_done) autobaud_enable_reg <= 1'b0; // [RULE23]
            if (ab_ovf_set) autobaud_overflow_flag_reg <= 1'b1; // [RULE23]
            else if (wr_baud && !wdata_i[`LBW_B_AUTOBAUD_OVERFLOW_FLAG] && !autobaud_enable_reg
                     && !wdata_i[`LBW_B_AUTOBAUD_ENABLE])
                autobaud_overflow_flag_reg <= 1'b0; // [RULE2] [RULE3]
            if (wr_div) divisor_reg <= wdata_i;
            else if (ab_done) divisor_reg <= {3'h0, ab_cnt_reg[15:3]};
        end
    end

    // Transmit control bits; break-send self clears after stop bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            transmit_enable_reg <= 1'b0;
            break_send_bit_reg  <= 1'b0;
            sync_mode_reg       <= 1'b0;
        end else if (wr_txctl) begin
            transmit_enable_reg <= wdata_i[`LBW_B_TRANSMIT_ENABLE];
            break_send_bit_reg  <= wdata_i[`LBW_B_BREAK_SEND_BIT];
            sync_mode_reg       <= wdata_i[`LBW_B_SYNC];
        end else if (tx_brk_done) begin
            break_send_bit_reg  <= 1'b0; // [RULE16]
        end
    end

    // Receive pending: any set wins over the read clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rx_pending_flag_reg <= 1'b0;
        else if (wake_event || ab_done || rx_done) rx_pending_flag_reg <= 1'b1; // [RULE8] [RULE21]
        else if (rd_rxdata) rx_pending_flag_reg <= 1'b0; // [RULE1] [RULE9]
    end

    // ==========================================================
    // Auto-baud measurement over the sync byte
    lbw_abd_state_e ab_state_reg;
    logic [2:0]     ab_edges_reg;
    logic           ab_run;

    // Held idle by wake and sleep so it follows the break [RULE22]
    assign ab_run     = autobaud_enable_reg && !wake_enable_reg && !sleep_i;
    assign ab_done    = (ab_state_reg == AB_COUNT) && rx_rise && (ab_edges_reg == `LBW_ABD_LAST);
    assign ab_ovf_set = (ab_state_reg == AB_COUNT) && (ab_cnt_reg == 16'hFFFF);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ab_state_reg <= AB_IDLE;
            ab_cnt_reg   <= 16'h0000;
            ab_edges_reg <= 3'h0;
        end else if (!ab_run) begin
            ab_state_reg <= AB_IDLE;
        end else begin
            case (ab_state_reg)
                AB_IDLE:  if (rx_fall) ab_state_reg <= AB_START;
                AB_START: if (rx_rise) begin
                    ab_cnt_reg   <= 16'h0001;
                    ab_edges_reg <= 3'h1;
                    ab_state_reg <= AB_COUNT;
                end
                AB_COUNT: begin
                    ab_cnt_reg <= ab_cnt_reg + 16'h0001; // Wraps past overflow [RULE23]
                    if (rx_rise) ab_edges_reg <= ab_edges_reg + 3'h1;
                    if (ab_done) ab_state_reg <= AB_IDLE;
                end
                default:  ab_state_reg <= AB_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Character receiver, 8N1, mid-bit sampling
    lbw_rx_state_e rx_state_reg;
    logic [15:0]   rx_cnt_reg;
    logic [2:0]    rx_bit_reg;
    logic [7:0]    rx_shift_reg;
    logic          rx_run;

    // Held idle by sleep, wake and auto-baud [RULE4] [RULE6] [RULE24]
    assign rx_run  = !sleep_i && !wake_enable_reg && !autobaud_enable_reg;
    assign rx_done = (rx_state_reg == RX_STOP) && (rx_cnt_reg == 16'h0000);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state_reg <= RX_IDLE;
            rx_cnt_reg   <= 16'h0000;
            rx_bit_reg   <= 3'h0;
            rx_shift_reg <= 8'h00;
        end else if (!rx_run) begin
            rx_state_reg <= RX_IDLE;
        end else begin
            if (rx_cnt_reg != 16'h0000) rx_cnt_reg <= rx_cnt_reg - 16'h0001;
            case (rx_state_reg)
                RX_IDLE: if (rx_fall) begin
                    rx_cnt_reg   <= divisor_reg >> 1;
                    rx_state_reg <= RX_START;
                end
                RX_START: if (rx_cnt_reg == 16'h0000) begin
                    rx_cnt_reg   <= divisor_reg - 16'h0001;
                    rx_bit_reg   <= 3'h0;
                    rx_state_reg <= rx_s ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_cnt_reg == 16'h0000) begin
                    rx_shift_reg <= {rx_s, rx_shift_reg[7:1]};
                    rx_bit_reg   <= rx_bit_reg + 3'h1;
                    rx_cnt_reg   <= divisor_reg - 16'h0001;
                    if (rx_bit_reg == 3'h7) rx_state_reg <= RX_STOP;
                end
                RX_STOP: if (rx_done) rx_state_reg <= RX_IDLE;
                default: rx_state_reg <= RX_IDLE;
            endcase
        end
    end

    // Data and framing error land with the pending flag [RULE20]
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_data_reg            <= 8'h00;
            framing_error_flag_reg <= 1'b0;
        end else if (rx_run && rx_done) begin
            rx_data_reg            <= rx_shift_reg;
            framing_error_flag_reg <= ~rx_s;
        end
    end

    // ==========================================================
    // Transmitter: one buffer byte and a shifter
    logic [7:0]  tx_buf_reg;
    logic        tx_buf_empty_reg, tx_buf_brk_reg;
    logic        tx_idle_reg, tx_brk_reg, txd_reg;
    logic [12:0] tx_shift_reg;
    logic [3:0]  tx_left_reg;
    logic [15:0] tx_cnt_reg;
    logic        tx_load, brk_queued, tx_bit_end;

    assign tx_load     = !tx_buf_empty_reg && tx_idle_reg && transmit_enable_reg;
    assign brk_queued  = (!tx_buf_empty_reg && tx_buf_brk_reg) || (!tx_idle_reg && tx_brk_reg);
    assign tx_bit_end  = !tx_idle_reg && (tx_cnt_reg == 16'h0000);
    assign tx_brk_done = tx_bit_end && (tx_left_reg == 4'h0) && tx_brk_reg;

    // Buffer: a write while full is dropped; empty flag [RULE19]
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_buf_reg       <= 8'h00;
            tx_buf_empty_reg <= 1'b1;
            tx_buf_brk_reg   <= 1'b0;
        end else if (wr_txdata && tx_buf_empty_reg) begin
            tx_buf_reg       <= wdata_i[7:0];
            tx_buf_empty_reg <= 1'b0;
            // Only the first write after break-send is a break [RULE15] [RULE18]
            tx_buf_brk_reg   <= break_send_bit_reg && !brk_queued;
        end else if (tx_load) begin
            tx_buf_empty_reg <= 1'b1; // [RULE19]
        end
    end

    // Shifter: start bit, then data or twelve zeros, then stop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_idle_reg  <= 1'b1;
            tx_brk_reg   <= 1'b0;
            txd_reg      <= 1'b1;
            tx_shift_reg <= 13'h0000;
            tx_left_reg  <= 4'h0;
            tx_cnt_reg   <= 16'h0000;
        end else if (tx_load) begin
            tx_idle_reg  <= 1'b0; // [RULE17]
            tx_brk_reg   <= tx_buf_brk_reg;
            txd_reg      <= 1'b0;
            tx_cnt_reg   <= divisor_reg - 16'h0001;
            if (tx_buf_brk_reg) begin
                tx_shift_reg <= {1'b1, 12'h000}; // Value written is ignored [RULE14] [RULE15]
                tx_left_reg  <= `LBW_BRK_LEFT;
            end else begin
                tx_shift_reg <= {4'h0, 1'b1, tx_buf_reg};
                tx_left_reg  <= `LBW_CHR_LEFT;
            end
        end else if (tx_bit_end) begin
            tx_cnt_reg <= divisor_reg - 16'h0001;
            if (tx_left_reg == 4'h0) begin
                tx_idle_reg <= 1'b1; // [RULE17]
                txd_reg     <= 1'b1;
            end else begin
                txd_reg      <= tx_shift_reg[0];
                tx_shift_reg <= tx_shift_reg >> 1;
                tx_left_reg  <= tx_left_reg - 4'h1;
            end
        end else if (!tx_idle_reg) begin
            tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        end
    end

    // ==========================================================
    // Read port: data in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rdata_o <= 16'h0000;
        else if (rd_i) begin
            case (addr_i)
                `LBW_A_BAUD:   rdata_o <= {12'h000, rx_state_reg == RX_IDLE, wake_enable_reg,
                                           autobaud_overflow_flag_reg, autobaud_enable_reg};
                `LBW_A_TXCTL:  rdata_o <= {11'h000, sync_mode_reg, tx_buf_empty_reg,
                                           tx_idle_reg, break_send_bit_reg, transmit_enable_reg};
                `LBW_A_RXSTAT: rdata_o <= {14'h0000, framing_error_flag_reg, rx_pending_flag_reg};
                `LBW_A_RXDATA: rdata_o <= {8'h00, rx_data_reg};
                `LBW_A_DIV:    rdata_o <= divisor_reg;
                default:       rdata_o <= 16'h0000;
            endcase
        end else rdata_o <= 16'h0000;
    end

    assign txd_o             = txd_reg;
    assign rx_pending_o      = rx_pending_flag_reg;
    assign tx_buffer_empty_o = tx_buf_empty_reg;
    assign tx_shift_empty_o  = tx_idle_reg;

    // ==========================================================
    // Assertions
    logic [19:0] low_run_reg;

    // Length of the current low run on the transmit line
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) low_run_reg <= 20'h0_0000;
        else if (txd_reg) low_run_reg <= 20'h0_0000;
        else low_run_reg <= low_run_reg + 20'h0_0001;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_read_clears;
        rd_rxdata && !wake_event && !ab_done && !rx_done |=> !rx_pending_o;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("pending not cleared"); // [RULE9]

    property p_ovf_clear;
        wr_baud && !wdata_i[1] && !wdata_i[0] && !autobaud_enable_reg && !ab_ovf_set
            |=> !autobaud_overflow_flag_reg;
    endproperty
    a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared"); // [RULE2]

    property p_ovf_kept;
        autobaud_enable_reg && autobaud_overflow_flag_reg |=> autobaud_overflow_flag_reg;
    endproperty
    a_ovf_kept: assert property (p_ovf_kept) else $error("overflow lost while enabled"); // [RULE3]

    property p_rx_held;
        (wake_enable_reg || autobaud_enable_reg || sleep_i) |=> rx_state_reg == RX_IDLE;
    endproperty
    a_rx_held: assert property (p_rx_held) else $error("receiver ran while held"); // [RULE6]

    property p_wake_flag;
        wake_event |=> rx_pending_o && wake_seen_reg;
    endproperty
    a_wake_flag: assert property (p_wake_flag) else $error("wake did not flag"); // [RULE8]

    property p_wake_end;
        wake_seen_reg && rx_rise && !wr_baud |=> !wake_enable_reg ##1 rx_state_reg == RX_IDLE;
    endproperty
    a_wake_end: assert property (p_wake_end) else $error("wake not ended"); // [RULE10]

    property p_brk_len;
        $rose(txd_reg) && tx_brk_reg |-> low_run_reg == ({4'h0, divisor_reg} * `LBW_BRK_LOW);
    endproperty
    a_brk_len: assert property (p_brk_len) else $error("break low time wrong"); // [RULE14]

    property p_brk_clr;
        tx_brk_done && !wr_txctl |=> !break_send_bit_reg && tx_shift_empty_o;
    endproperty
    a_brk_clr: assert property (p_brk_clr) else $error("break-send not cleared"); // [RULE16]

    property p_tse_busy;
        tx_load && tx_buf_brk_reg |=> !tx_shift_empty_o ##1 !tx_shift_empty_o;
    endproperty
    a_tse_busy: assert property (p_tse_busy) else $error("shift empty during break"); // [RULE17]

    property p_rx_break;
        rx_run && rx_done && rx_shift_reg == 8'h00 && !rx_s
            |=> rx_pending_o && framing_error_flag_reg && rx_data_reg == 8'h00;
    endproperty
    a_rx_break: assert property (p_rx_break) else $error("break not reported"); // [RULE20]

    property p_abd_done;
        ab_done && !wr_baud |=> !autobaud_enable_reg && rx_pending_o;
    endproperty
    a_abd_done: assert property (p_abd_done) else $error("auto-baud end wrong"); // [RULE23]

    c_wake:  cover property (wake_event ##[1:1000] !wake_enable_reg);
    c_break: cover property (tx_brk_done);
    c_abd:   cover property (ab_done);
    c_rxbrk: cover property (rx_done && rx_shift_reg == 8'h00 && !rx_s);
endmodule

// [core/lbw_sync.sv]
// Two-stage synchroniser for the receive line
// Assumes an idle-high line; resets to high
module lbw_sync (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_reg;

    // First stage is read only by the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= 1'b1;
            q_o      <= 1'b1;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule

// [shared/lbw_defs.svh]
// Register map, field positions, reset values and frame lengths
// Assumes a byte address on a plain strobe bus, 16-bit data
`ifndef LBW_DEFS_SVH
`define LBW_DEFS_SVH

// ==========================================================
// Register offsets
`define LBW_A_BAUD    8'h00
`define LBW_A_TXCTL   8'h04
`define LBW_A_RXSTAT  8'h08
`define LBW_A_RXDATA  8'h0C
`define LBW_A_TXDATA  8'h10
`define LBW_A_DIV     8'h14

// ==========================================================
// Field positions
`define LBW_B_AUTOBAUD_ENABLE   0
`define LBW_B_AUTOBAUD_OVERFLOW_FLAG  1
`define LBW_B_WAKE    2
`define LBW_B_RXIDLE  3
`define LBW_B_TRANSMIT_ENABLE    0
`define LBW_B_BREAK_SEND_BIT   1
`define LBW_B_TSEMP   2
`define LBW_B_TBEMP   3
`define LBW_B_SYNC    4
`define LBW_B_PEND    0
`define LBW_B_FRAMING_ERROR_FLAG    1

// ==========================================================
// Reset values and frame lengths
`define LBW_DIV_RST   16'h00D9
`define LBW_BRK_LEFT  4'hD
`define LBW_CHR_LEFT  4'h9
`define LBW_BRK_LOW   20'h0_000D
`define LBW_ABD_LAST  3'h4

`endif

// [shared/lbw_pkg.sv]
// State types of the serial wake and break logic
// Assumes nothing beyond the compile order
package lbw_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} lbw_rx_state_e;
    typedef enum logic [1:0] {AB_IDLE, AB_START, AB_COUNT} lbw_abd_state_e;
endpackage

// [tb/lbw_remote.sv]
// Remote serial node: drives the receive line, decodes the transmit line
// Assumes an idle-high line and a bit time given in clk_i cycles
module lbw_remote (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output logic      rxd_o
);
    timeunit 1ns;
    timeprecision 1ns;

    initial rxd_o = 1'b1;

    // ==========================================================
    // Line driving
    // One 8N1 frame, LSB first; a zero byte with a low stop bit makes a break frame
    task automatic send(input logic [7:0] b, input int bc, input logic stop);
        rxd_o <= 1'b0;
        repeat (bc) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            rxd_o <= b[i];
            repeat (bc) @(posedge clk_i);
        end
        rxd_o <= stop;
        repeat (bc) @(posedge clk_i);
        rxd_o <= 1'b1;
        repeat (2 * bc) @(posedge clk_i);
    endtask

    // Holds the line low, then back to idle high
    task automatic hold_low(input int n);
        rxd_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rxd_o <= 1'b1;
    endtask

    // ==========================================================
    // Line decoding
    // Measures break low run and stop gap, then samples the next byte mid-bit
    task automatic catch_hdr(input int bc, output int low, output int hi,
                             output logic [7:0] b);
        low = 0;
        hi  = 0;
        @(negedge txd_i);
        @(negedge clk_i);
        while (!txd_i) begin
            low++;
            @(negedge clk_i);
        end
        while (txd_i) begin
            hi++;
            @(negedge clk_i);
        end
        repeat (bc + bc / 2) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            b[i] = txd_i;
            repeat (bc) @(negedge clk_i);
        end
    endtask
endmodule

// [tb/uart_lin_break_wake_logic_tb.sv]
// Self-checking bench for the serial wake and break logic
// Assumes the register map header and the remote node model
`include "lbw_defs.svh"
module uart_lin_break_wake_logic_tb;
    import lbw_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        sleep_i = 1'b0;
    logic [15:0] rdata_o;
    logic        rxd_i;
    logic        txd_o;
    logic        rx_pending_o;
    logic        tx_buffer_empty_o;
    logic        tx_shift_empty_o;
    int          n_errors = 0;
    int          tests_run = 0;

    // ==========================================================
    // Clock, design and remote node
    always #20 clk_i = ~clk_i;

    lbw_core u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .sleep_i(sleep_i),
        .txd_o(txd_o), .rx_pending_o(rx_pending_o), .tx_buffer_empty_o(tx_buffer_empty_o),
        .tx_shift_empty_o(tx_shift_empty_o));
    lbw_remote u_remote (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_i));

    // ==========================================================
    // Bus and compare helpers
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read, mask and compare; data are taken in the cycle after the strobe
    task automatic rchk(input string what, input logic [7:0] a, input logic [15:0] m,
                        input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(what, exp, rdata_o & m);
    endtask

    // One received frame: pending, status and data, then read clears pending
    task automatic rx_frame(input logic [7:0] b, input logic stop, input logic [15:0] st);
        u_remote.send(b, 8, stop);
        chk("pending", 16'h0001, {15'h0000, rx_pending_o});
        rchk("rxstat", `LBW_A_RXSTAT, 16'h0003, st);
        rchk("rxdata", `LBW_A_RXDATA, 16'h00FF, {8'h00, b});
        chk("pending clr", 16'h0000, {15'h0000, rx_pending_o});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk("idle out", 16'h000E, {12'h000, txd_o, tx_shift_empty_o, tx_buffer_empty_o,
            rx_pending_o});
        rchk("div rst", `LBW_A_DIV, 16'hFFFF, `LBW_DIV_RST);
        rchk("txctl rst", `LBW_A_TXCTL, 16'h001F, 16'h000C);
        wr(8'h20, 16'hFFFF);
        rchk("unmapped", 8'h20, 16'hFFFF, 16'h0000);
        wr(`LBW_A_DIV, 16'h0008);
        $display("test reset done");
    endtask

    task automatic t_rx();
        rx_frame(8'h00, 1'b0, 16'h0003);
        rx_frame(8'hA5, 1'b1, 16'h0001);
        $display("test receive done");
    endtask

    task automatic t_wake();
        sleep_i <= 1'b1;
        u_remote.send(8'hA5, 8, 1'b1);
        chk("sleep rx", 16'h0000, {15'h0000, rx_pending_o});
        wr(`LBW_A_TXCTL, 16'h0010);
        wr(`LBW_A_BAUD, 16'h0004);
        rchk("sync wake", `LBW_A_BAUD, 16'h0004, 16'h0000);
        wr(`LBW_A_TXCTL, 16'h0000);
        rchk("rx idle", `LBW_A_BAUD, 16'h0008, 16'h0008);
        wr(`LBW_A_BAUD, 16'h0004);
        fork
            u_remote.hold_low(104);
            begin
                repeat (6) @(posedge clk_i);
                chk("wake pend", 16'h0001, {15'h0000, rx_pending_o});
                rchk("wake held", `LBW_A_BAUD, 16'h0004, 16'h0004);
            end
        join
        repeat (8) @(posedge clk_i);
        rchk("wake clr", `LBW_A_BAUD, 16'h0004, 16'h0000);
        rchk("no frame", `LBW_A_RXSTAT, 16'h0003, 16'h0001);
        rchk("discard", `LBW_A_RXDATA, 16'h0000, 16'h0000);
        chk("wake read", 16'h0000, {15'h0000, rx_pending_o});
        sleep_i <= 1'b0;
        rx_frame(8'h3C, 1'b1, 16'h0001);
        $display("test wake done");
    endtask

    task automatic t_break_tx();
        int low;
        int hi;
        logic [7:0] b;
        fork
            u_remote.catch_hdr(8, low, hi, b);
            begin
                wr(`LBW_A_TXCTL, 16'h0003);
                wr(`LBW_A_TXDATA, 16'h00FF);
                repeat (3) @(posedge clk_i);
                chk("shift busy", 16'h0000, {15'h0000, tx_shift_empty_o});
                chk("buf empty", 16'h0001, {15'h0000, tx_buffer_empty_o});
                wr(`LBW_A_TXDATA, 16'h0055);
            end
        join
        chk("break low", 16'd104, low[15:0]);
        chk("break stop", 16'd9, hi[15:0]);
        chk("sync byte", 16'h0055, {8'h00, b});
        for (int n = 0; n < 200 && tx_shift_empty_o !== 1'b1; n++) @(negedge clk_i);
        chk("shift idle", 16'h0001, {15'h0000, tx_shift_empty_o});
        rchk("break_send_bit clr", `LBW_A_TXCTL, 16'h000B, 16'h0009);
        $display("test break transmit done");
    endtask

    task automatic t_autobaud();
        sleep_i <= 1'b1; // Armed while asleep
        wr(`LBW_A_BAUD, 16'h0001);
        sleep_i <= 1'b0;
        u_remote.send(8'h55, 16, 1'b1);
        chk("abd pend", 16'h0001, {15'h0000, rx_pending_o});
        rchk("abd done", `LBW_A_BAUD, 16'h0003, 16'h0000);
        rchk("abd div", `LBW_A_DIV, 16'hFFFF, 16'h0010);
        rchk("abd read", `LBW_A_RXDATA, 16'h0000, 16'h0000);
        chk("abd clr", 16'h0000, {15'h0000, rx_pending_o});
        wr(`LBW_A_BAUD, 16'h0001);
        u_remote.hold_low(16);
        repeat (65600) @(posedge clk_i);
        rchk("ovf set", `LBW_A_BAUD, 16'h0003, 16'h0003);
        wr(`LBW_A_BAUD, 16'h0001);
        rchk("ovf kept", `LBW_A_BAUD, 16'h0003, 16'h0003);
        wr(`LBW_A_BAUD, 16'h0000);
        rchk("ovf order", `LBW_A_BAUD, 16'h0003, 16'h0002);
        wr(`LBW_A_BAUD, 16'h0000);
        rchk("ovf clr", `LBW_A_BAUD, 16'h0003, 16'h0000);
        $display("test autobaud done");
    endtask

    // ==========================================================
    // Verdict, watchdog and main sequence
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_rx();
        t_wake();
        t_break_tx();
        t_autobaud();
        final_report();
    end
endmodule
